/* smem_cfg.svh */
// constants shared by both ends of the two-wire serial memory link
`ifndef SMEM_CFG_SVH
`define SMEM_CFG_SVH

// ----------------------------------------------------------------
// addressing and byte layout
// ----------------------------------------------------------------
`define SMEM_DEV_TYPE    4'hA
`define SMEM_HS_CODE     5'h01
`define SMEM_HS_BYTE     8'h08
`define SMEM_ADDR_MAX    14'h3FFF
`define SMEM_ADDR_MIN    14'h0000
`define SMEM_LAST_BIT    4'h7
`define SMEM_ACK_BIT     4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SMEM_CLK_NS      25
`define SMEM_F_STD_KHZ   100
`define SMEM_F_HS_KHZ    3400
`define SMEM_QTR_STD_CYC ((1000000 + 4*`SMEM_F_STD_KHZ*`SMEM_CLK_NS - 1) / (4*`SMEM_F_STD_KHZ*`SMEM_CLK_NS))
`define SMEM_QTR_HS_CYC  ((1000000 + 4*`SMEM_F_HS_KHZ*`SMEM_CLK_NS - 1) / (4*`SMEM_F_HS_KHZ*`SMEM_CLK_NS))

// ----------------------------------------------------------------
// master step program
// ----------------------------------------------------------------
`define SMEM_STEP_HS     4'h0
`define SMEM_STEP_START  4'h2
`define SMEM_STEP_FAIL   4'h9

`endif

/* smem_pkg.sv */
// types shared by both ends of the two-wire serial memory link
package smem_pkg;

  typedef enum logic [5:0] {
    SL_IDLE  = 6'h01,
    SL_SLAVE = 6'h02,
    SL_AHI   = 6'h04,
    SL_ALO   = 6'h08,
    SL_WR    = 6'h10,
    SL_RD    = 6'h20
  } smem_sl_state_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h1,
    MS_RUN  = 2'h2
  } smem_ms_state_t;

  typedef enum logic [3:0] {
    K_START = 4'h1,
    K_TX    = 4'h2,
    K_RX    = 4'h4,
    K_STOP  = 4'h8
  } smem_kind_t;

endpackage

/* smem_if.sv */
// two-wire link between the bus master and the serial memory
`timescale 1ns/1ps
interface smem_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;

  // wired-and of both open-drain drivers with the pull-up
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport host (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

/* smem_slave.sv */
// serial memory slave end: start/stop detection, addressing, 16K x 8 array
`timescale 1ns/1ps
`include "smem_cfg.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module smem_slave (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  smem_if.dev             bus,
  input  wire logic [2:0] device_select_pins,
  input  wire logic       write_protect,
  output logic            hs_active,
  output logic            byte_written
);

  function automatic logic [13:0] smem_addr_inc(input logic [13:0] a);
    smem_addr_inc = (a == `SMEM_ADDR_MAX) ? `SMEM_ADDR_MIN : a + 14'h0001;
  endfunction

  // ----------------------------------------------------------------
  // start and stop detection, clocked by sda itself
  // ----------------------------------------------------------------
  logic start_tog_reg;
  logic start_tog_next;
  logic stop_tog_reg;
  logic stop_tog_next;

  always_comb
  begin
    start_tog_next = bus.scl ? ~start_tog_reg : start_tog_reg;
    stop_tog_next  = bus.scl ? ~stop_tog_reg : stop_tog_reg;
  end

  always_ff @(negedge bus.sda or negedge arst_n)
  begin
    if (!arst_n)
      start_tog_reg <= 1'b0;
    else
      start_tog_reg <= start_tog_next;
  end

  always_ff @(posedge bus.sda or negedge arst_n)
  begin
    if (!arst_n)
      stop_tog_reg <= 1'b0;
    else
      stop_tog_reg <= stop_tog_next;
  end

  // ----------------------------------------------------------------
  // bit sampling on scl rise
  // ----------------------------------------------------------------
  logic rx_bit_reg;

  always_ff @(posedge bus.scl or negedge arst_n)
  begin
    if (!arst_n)
      rx_bit_reg <= 1'b1;
    else
      rx_bit_reg <= bus.sda;
  end

  // ----------------------------------------------------------------
  // protocol engine on scl fall
  // ----------------------------------------------------------------
  smem_pkg::smem_sl_state_t state_reg;
  smem_pkg::smem_sl_state_t state_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic [7:0]  tx_reg;
  logic [7:0]  tx_next;
  logic [5:0]  ahi_reg;
  logic [5:0]  ahi_next;
  logic [13:0] addr_reg;
  logic [13:0] addr_next;
  logic        rd_reg;
  logic        rd_next;
  logic        oe_reg;
  logic        oe_next;
  logic        hs_reg;
  logic        hs_next;
  logic        start_seen_reg;
  logic        stop_seen_reg;
  logic        wr_tog_reg;
  logic        wr_tog_next;
  logic [2:0]  sel_s1_reg;
  logic [2:0]  sel_s2_reg;
  logic        wp_s1_reg;
  logic        wp_s2_reg;
  logic [7:0]  byte_in;
  logic [7:0]  mem_rd;
  logic        mem_we;
  logic        ack;
  logic        start_pend;
  logic        stop_pend;
  logic [7:0]  mem_array [0:16383];

  assign byte_in = {sh_reg[6:0], rx_bit_reg};
  assign mem_rd  = mem_array[addr_reg];
  // sda edges lead the following scl fall by the bus setup time, so the toggles are settled here
  assign start_pend = start_tog_reg != start_seen_reg;
  assign stop_pend  = stop_tog_reg != stop_seen_reg;

  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    sh_next     = sh_reg;
    tx_next     = tx_reg;
    ahi_next    = ahi_reg;
    addr_next   = addr_reg;
    rd_next     = rd_reg;
    oe_next     = oe_reg;
    hs_next     = hs_reg;
    wr_tog_next = wr_tog_reg;
    mem_we      = 1'b0;
    ack         = 1'b0;
    if (start_pend)
    begin
      state_next = smem_pkg::SL_SLAVE;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end
    else if (stop_pend)
    begin
      state_next = smem_pkg::SL_IDLE;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
      hs_next    = 1'b0;
    end
    else
    begin
      case (state_reg)
        smem_pkg::SL_IDLE:
        begin
          oe_next = 1'b0;
        end
        smem_pkg::SL_RD:
        begin
          if (cnt_reg < `SMEM_LAST_BIT)
          begin
            tx_next  = {tx_reg[6:0], 1'b0};
            oe_next  = ~tx_reg[6];
            cnt_next = cnt_reg + 4'h1;
          end
          else if (cnt_reg == `SMEM_LAST_BIT)
          begin
            oe_next   = 1'b0;
            cnt_next  = `SMEM_ACK_BIT;
            addr_next = smem_addr_inc(addr_reg);
          end
          else if (!rx_bit_reg)
          begin
            tx_next  = mem_rd;
            oe_next  = ~mem_rd[7];
            cnt_next = 4'h0;
          end
          else
          begin
            state_next = smem_pkg::SL_IDLE;
            oe_next    = 1'b0;
            cnt_next   = 4'h0;
          end
        end
        default:
        begin
          if (cnt_reg < `SMEM_LAST_BIT)
          begin
            sh_next  = byte_in;
            cnt_next = cnt_reg + 4'h1;
          end
          else if (cnt_reg == `SMEM_LAST_BIT)
          begin
            cnt_next = `SMEM_ACK_BIT;
            case (state_reg)
              smem_pkg::SL_SLAVE:
              begin
                if (byte_in[7:4] == `SMEM_DEV_TYPE && byte_in[3:1] == sel_s2_reg)
                begin
                  ack     = 1'b1;
                  rd_next = byte_in[0];
                end
                else if (byte_in[7:3] == `SMEM_HS_CODE)
                  hs_next = 1'b1;
              end
              smem_pkg::SL_AHI:
              begin
                ack      = 1'b1;
                ahi_next = byte_in[5:0];
              end
              smem_pkg::SL_ALO:
              begin
                ack       = 1'b1;
                addr_next = {ahi_reg, byte_in};
              end
              default:
              begin
                if (!wp_s2_reg)
                begin
                  ack         = 1'b1;
                  mem_we      = 1'b1;
                  wr_tog_next = ~wr_tog_reg;
                  addr_next   = smem_addr_inc(addr_reg);
                end
              end
            endcase
            oe_next = ack;
            if (!ack)
              state_next = smem_pkg::SL_IDLE;
          end
          else
          begin
            oe_next  = 1'b0;
            cnt_next = 4'h0;
            case (state_reg)
              smem_pkg::SL_SLAVE:
              begin
                if (rd_reg)
                begin
                  state_next = smem_pkg::SL_RD;
                  tx_next    = mem_rd;
                  oe_next    = ~mem_rd[7];
                end
                else
                  state_next = smem_pkg::SL_AHI;
              end
              smem_pkg::SL_AHI:
                state_next = smem_pkg::SL_ALO;
              default:
                state_next = smem_pkg::SL_WR;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(negedge bus.scl or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg      <= smem_pkg::SL_IDLE;
      cnt_reg        <= 4'h0;
      sh_reg         <= 8'h00;
      tx_reg         <= 8'h00;
      ahi_reg        <= 6'h00;
      addr_reg       <= `SMEM_ADDR_MIN;
      rd_reg         <= 1'b0;
      oe_reg         <= 1'b0;
      hs_reg         <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
      wr_tog_reg     <= 1'b0;
      sel_s1_reg     <= 3'h0;
      sel_s2_reg     <= 3'h0;
      wp_s1_reg      <= 1'b0;
      wp_s2_reg      <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      sh_reg         <= sh_next;
      tx_reg         <= tx_next;
      ahi_reg        <= ahi_next;
      addr_reg       <= addr_next;
      rd_reg         <= rd_next;
      oe_reg         <= oe_next;
      hs_reg         <= hs_next;
      start_seen_reg <= start_tog_reg;
      stop_seen_reg  <= stop_tog_reg;
      wr_tog_reg     <= wr_tog_next;
      sel_s1_reg     <= device_select_pins;
      sel_s2_reg     <= sel_s1_reg;
      wp_s1_reg      <= write_protect;
      wp_s2_reg      <= wp_s1_reg;
    end
  end

  // array holds no reset: contents must survive like the real cells
  always_ff @(negedge bus.scl)
  begin
    if (mem_we)
      mem_array[addr_reg] <= byte_in;
  end

  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = oe_reg;

  // ----------------------------------------------------------------
  // status into the system clock domain
  // ----------------------------------------------------------------
  logic hs_s1_reg;
  logic hs_s2_reg;
  logic wr_s1_reg;
  logic wr_s2_reg;
  logic wr_s3_reg;
  logic bw_reg;
  logic bw_next;

  assign bw_next = wr_s2_reg ^ wr_s3_reg;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hs_s1_reg <= 1'b0;
      hs_s2_reg <= 1'b0;
      wr_s1_reg <= 1'b0;
      wr_s2_reg <= 1'b0;
      wr_s3_reg <= 1'b0;
      bw_reg    <= 1'b0;
    end
    else
    begin
      // a stop leaves scl idle, so the pending stop masks the flag at once
      hs_s1_reg <= hs_reg & ~stop_pend;
      hs_s2_reg <= hs_s1_reg;
      wr_s1_reg <= wr_tog_reg;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg;
      bw_reg    <= bw_next;
    end
  end

  assign hs_active    = hs_s2_reg;
  assign byte_written = bw_reg;

endmodule

/* smem_master.sv */
// bus master end: generates scl and runs single-byte writes and selective reads
`timescale 1ns/1ps
`include "smem_cfg.svh"
module smem_master (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  smem_if.host             bus,
  input  wire logic        req,
  input  wire logic        req_read,
  input  wire logic        req_hs,
  input  wire logic [2:0]  req_sel,
  input  wire logic [13:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             busy,
  output logic             done,
  output logic             nack_err,
  output logic [7:0]       rd_data
);

  function automatic smem_pkg::smem_kind_t smem_step_kind(input logic [3:0] s, input logic rd);
    case (s)
      4'h0, 4'h2: smem_step_kind = smem_pkg::K_START;
      4'h1, 4'h3, 4'h4, 4'h5: smem_step_kind = smem_pkg::K_TX;
      4'h6: smem_step_kind = rd ? smem_pkg::K_START : smem_pkg::K_TX;
      4'h7: smem_step_kind = rd ? smem_pkg::K_TX : smem_pkg::K_STOP;
      4'h8: smem_step_kind = smem_pkg::K_RX;
      default: smem_step_kind = smem_pkg::K_STOP;
    endcase
  endfunction

  function automatic logic [7:0] smem_step_byte(input logic [3:0] s, input logic [2:0] sel,
                                                input logic [13:0] a, input logic [7:0] d);
    case (s)
      4'h1: smem_step_byte = `SMEM_HS_BYTE;
      4'h3: smem_step_byte = {`SMEM_DEV_TYPE, sel, 1'b0};
      4'h4: smem_step_byte = {2'h0, a[13:8]};
      4'h5: smem_step_byte = a[7:0];
      4'h6: smem_step_byte = d;
      4'h7: smem_step_byte = {`SMEM_DEV_TYPE, sel, 1'b1};
      default: smem_step_byte = 8'hFF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  smem_pkg::smem_ms_state_t state_reg;
  smem_pkg::smem_ms_state_t state_next;
  logic [3:0]  step_reg;
  logic [3:0]  step_next;
  logic [1:0]  q_reg;
  logic [1:0]  q_next;
  logic [6:0]  div_reg;
  logic [6:0]  div_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic        scl_reg;
  logic        scl_next;
  logic        oe_reg;
  logic        oe_next;
  logic        fast_reg;
  logic        fast_next;
  logic        nak_reg;
  logic        nak_next;
  logic        rd_reg;
  logic        rd_next;
  logic [2:0]  sel_reg;
  logic [2:0]  sel_next;
  logic [13:0] addr_reg;
  logic [13:0] addr_next;
  logic [7:0]  wd_reg;
  logic [7:0]  wd_next;
  logic        busy_reg;
  logic        busy_next;
  logic        done_reg;
  logic        done_next;
  logic        err_reg;
  logic        err_next;
  logic [7:0]  rdd_reg;
  logic [7:0]  rdd_next;
  logic        sda_s1_reg;
  logic        sda_s2_reg;
  logic        tick;
  logic        advance;

  always_comb
  begin
    state_next = state_reg;
    step_next  = step_reg;
    q_next     = q_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    scl_next   = scl_reg;
    oe_next    = oe_reg;
    fast_next  = fast_reg;
    nak_next   = nak_reg;
    rd_next    = rd_reg;
    sel_next   = sel_reg;
    addr_next  = addr_reg;
    wd_next    = wd_reg;
    busy_next  = busy_reg;
    err_next   = err_reg;
    rdd_next   = rdd_reg;
    done_next  = 1'b0;
    advance    = 1'b0;
    tick       = (div_reg == 7'h00);
    if (tick)
      div_next = fast_reg ? 7'(`SMEM_QTR_HS_CYC - 1) : 7'(`SMEM_QTR_STD_CYC - 1);
    else
      div_next = div_reg - 7'h01;
    case (state_reg)
      smem_pkg::MS_IDLE:
      begin
        scl_next = 1'b1;
        oe_next  = 1'b0;
        div_next = 7'(`SMEM_QTR_STD_CYC - 1);
        if (req)
        begin
          state_next = smem_pkg::MS_RUN;
          step_next  = req_hs ? `SMEM_STEP_HS : `SMEM_STEP_START;
          rd_next    = req_read;
          sel_next   = req_sel;
          addr_next  = req_addr;
          wd_next    = req_wdata;
          q_next     = 2'h0;
          bit_next   = 4'h0;
          busy_next  = 1'b1;
          err_next   = 1'b0;
        end
      end
      smem_pkg::MS_RUN:
      begin
        if (tick)
        begin
          q_next = q_reg + 2'h1;
          case (smem_step_kind(step_reg, rd_reg))
            smem_pkg::K_START:
            begin
              case (q_reg)
                2'h0: begin scl_next = 1'b0; oe_next = 1'b0; end
                2'h1: scl_next = 1'b1;
                2'h2: oe_next = 1'b1;
                default: begin scl_next = 1'b0; advance = 1'b1; end
              endcase
            end
            smem_pkg::K_STOP:
            begin
              case (q_reg)
                2'h0: begin scl_next = 1'b0; oe_next = 1'b1; end
                2'h1: scl_next = 1'b1;
                2'h2: oe_next = 1'b0;
                default:
                begin
                  state_next = smem_pkg::MS_IDLE;
                  busy_next  = 1'b0;
                  done_next  = 1'b1;
                  fast_next  = 1'b0;
                end
              endcase
            end
            smem_pkg::K_TX:
            begin
              case (q_reg)
                2'h0: begin scl_next = 1'b0; oe_next = (bit_reg < `SMEM_ACK_BIT) & ~sh_reg[7]; end
                2'h1: scl_next = 1'b1;
                2'h2: nak_next = sda_s2_reg;
                default:
                begin
                  scl_next = 1'b0;
                  if (bit_reg < `SMEM_ACK_BIT)
                  begin
                    sh_next  = {sh_reg[6:0], 1'b1};
                    bit_next = bit_reg + 4'h1;
                  end
                  else if (step_reg == 4'h1)
                  begin
                    fast_next = 1'b1;
                    advance   = 1'b1;
                  end
                  else if (nak_reg)
                  begin
                    err_next  = 1'b1;
                    step_next = `SMEM_STEP_FAIL;
                    bit_next  = 4'h0;
                  end
                  else
                    advance = 1'b1;
                end
              endcase
            end
            default:
            begin
              case (q_reg)
                2'h0: begin scl_next = 1'b0; oe_next = 1'b0; end
                2'h1: scl_next = 1'b1;
                2'h2:
                begin
                  if (bit_reg < `SMEM_ACK_BIT)
                    sh_next = {sh_reg[6:0], sda_s2_reg};
                end
                default:
                begin
                  scl_next = 1'b0;
                  if (bit_reg == `SMEM_ACK_BIT)
                  begin
                    rdd_next = sh_reg;
                    advance  = 1'b1;
                  end
                  else
                    bit_next = bit_reg + 4'h1;
                end
              endcase
            end
          endcase
        end
      end
      default:
        state_next = smem_pkg::MS_IDLE;
    endcase
    if (advance)
    begin
      step_next = step_reg + 4'h1;
      bit_next  = 4'h0;
      sh_next   = smem_step_byte(step_reg + 4'h1, sel_reg, addr_reg, wd_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg  <= smem_pkg::MS_IDLE;
      step_reg   <= 4'h0;
      q_reg      <= 2'h0;
      div_reg    <= 7'h00;
      bit_reg    <= 4'h0;
      sh_reg     <= 8'hFF;
      scl_reg    <= 1'b1;
      oe_reg     <= 1'b0;
      fast_reg   <= 1'b0;
      nak_reg    <= 1'b0;
      rd_reg     <= 1'b0;
      sel_reg    <= 3'h0;
      addr_reg   <= 14'h0000;
      wd_reg     <= 8'h00;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      err_reg    <= 1'b0;
      rdd_reg    <= 8'h00;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end
    else
    begin
      state_reg  <= state_next;
      step_reg   <= step_next;
      q_reg      <= q_next;
      div_reg    <= div_next;
      bit_reg    <= bit_next;
      sh_reg     <= sh_next;
      scl_reg    <= scl_next;
      oe_reg     <= oe_next;
      fast_reg   <= fast_next;
      nak_reg    <= nak_next;
      rd_reg     <= rd_next;
      sel_reg    <= sel_next;
      addr_reg   <= addr_next;
      wd_reg     <= wd_next;
      busy_reg   <= busy_next;
      done_reg   <= done_next;
      err_reg    <= err_next;
      rdd_reg    <= rdd_next;
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  assign bus.scl      = scl_reg;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = oe_reg;
  assign busy         = busy_reg;
  assign done         = done_reg;
  assign nack_err     = err_reg;
  assign rd_data      = rdd_reg;

endmodule

/* smem_checker.sv */
// concurrent checks on the two-wire link between the master end and the memory end
`timescale 1ns/1ps
module smem_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic hs_active,
  input wire logic byte_written,
  input wire logic write_protect
);
  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  // scl is slow against clk_sys, so one system clock sees every link edge
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // device side of the wire
  // ----------------------------------------------------------------
  chk_oe_on_fall: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device sda enable moved while scl high");
  chk_open_drain: assert property (d_sda_oe |-> d_sda_o == 1'b0)
    else $error("device drives sda high");
  chk_start_free: assert property (scl && $fell(sda) |-> !d_sda_oe)
    else $error("device holds sda at a start");
  chk_stop_release: assert property (scl && $rose(sda) |=> !d_sda_oe [*8])
    else $error("device drives sda after a stop");
  chk_hs_exit: assert property (scl && $rose(sda) |-> ##[0:8] !hs_active)
    else $error("fast mode kept after a stop");
  chk_hs_no_ack: assert property ($rose(hs_active) |-> !d_sda_oe)
    else $error("master code acknowledged");
  chk_wr_pulse: assert property (byte_written |=> !byte_written)
    else $error("byte written pulse too long");
  chk_wr_protect: assert property (byte_written |-> !write_protect)
    else $error("array written while protected");
endmodule

/* i2c_serial_memory_slave_bench.sv */
// self-checking bench: master end and memory end joined over the two-wire link
`timescale 1ns/1ps
module i2c_serial_memory_slave_bench;
  logic        clk_sys;
  logic        arst_n;
  logic        req;
  logic        req_read;
  logic        req_hs;
  logic [2:0]  req_sel;
  logic [13:0] req_addr;
  logic [7:0]  req_wdata;
  logic [2:0]  device_select_pins;
  logic        write_protect;
  logic        busy;
  logic        done;
  logic        nack_err;
  logic [7:0]  rd_data;
  logic        hs_active;
  logic        byte_written;
  logic        saw_hs;
  int          n_wr;
  int          n_fail;
  int          n_checks;

  smem_if u_smem_if ();
  smem_master u_smem_master (.clk_sys(clk_sys), .arst_n(arst_n), .bus(u_smem_if.host), .req(req),
    .req_read(req_read), .req_hs(req_hs), .req_sel(req_sel), .req_addr(req_addr), .req_wdata(req_wdata),
    .busy(busy), .done(done), .nack_err(nack_err), .rd_data(rd_data));
  smem_slave u_smem_slave (.clk_sys(clk_sys), .arst_n(arst_n), .bus(u_smem_if.dev),
    .device_select_pins(device_select_pins), .write_protect(write_protect), .hs_active(hs_active),
    .byte_written(byte_written));
  smem_checker u_smem_checker (.clk_sys(clk_sys), .arst_n(arst_n), .scl(u_smem_if.scl), .sda(u_smem_if.sda),
    .d_sda_o(u_smem_if.d_sda_o), .d_sda_oe(u_smem_if.d_sda_oe), .hs_active(hs_active),
    .byte_written(byte_written), .write_protect(write_protect));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask

  // one master request; waits for done under a bound, noting fast mode and commits
  task automatic op(input logic rd, input logic hs, input logic [2:0] sel, input logic [13:0] a,
                    input logic [7:0] d);
    int n;
    n = 0;
    saw_hs = 1'b0;
    n_wr = 0;
    @(posedge clk_sys);
    req       <= 1'b1;
    req_read  <= rd;
    req_hs    <= hs;
    req_sel   <= sel;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge clk_sys);
    req <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n == 1)
        chk(busy === 1'b1, "busy not raised after request");
      if (hs_active === 1'b1)
        saw_hs = 1'b1;
      if (byte_written === 1'b1)
        n_wr++;
    end
    while (done !== 1'b1 && n < 40000);
    if (n >= 40000)
    begin
      chk(1'b0, "request never completed");
      stop_test();
    end
    chk(busy === 1'b0, "busy still high at done");
  endtask

  // ----------------------------------------------------------------
  // clock and sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    // nonblocking: the edge-clocked reset flops must see reset fall at time zero
    {arst_n, req, req_read, req_hs, write_protect} <= 5'h00;
    {req_sel, req_addr, req_wdata} <= 25'h0000000;
    device_select_pins <= 3'h5;
    n_fail = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    op(1'b0, 1'b0, 3'h5, 14'h3FFF, 8'h5A);
    chk(nack_err === 1'b0 && n_wr == 1, "plain write refused");
    op(1'b1, 1'b0, 3'h5, 14'h3FFF, 8'h00);
    chk(rd_data === 8'h5A && nack_err === 1'b0, "plain read back wrong");
    op(1'b0, 1'b1, 3'h5, 14'h0000, 8'hA5);
    chk(saw_hs === 1'b1 && nack_err === 1'b0 && n_wr == 1, "fast write failed");
    op(1'b1, 1'b1, 3'h5, 14'h0000, 8'h00);
    chk(rd_data === 8'hA5, "fast read back wrong");
    op(1'b0, 1'b0, 3'h2, 14'h3FFF, 8'h11);
    chk(nack_err === 1'b1 && n_wr == 0, "foreign select answered");
    @(posedge clk_sys);
    write_protect <= 1'b1;
    op(1'b0, 1'b1, 3'h5, 14'h3FFF, 8'h22);
    chk(nack_err === 1'b1 && n_wr == 0, "protected write taken");
    @(posedge clk_sys);
    write_protect <= 1'b0;
    op(1'b1, 1'b1, 3'h5, 14'h3FFF, 8'h00);
    chk(rd_data === 8'h5A && nack_err === 1'b0, "array altered by refused writes");
    stop_test();
  end
endmodule
